// ===== rtl/capture_sync.sv
`timescale 1ns/1ns
module capture_sync
(
    input wire logic ref_clk,
    input wire logic rstn,
    input wire logic enable,
    input wire logic polarity_rise,
    input wire logic pin_in,
    output logic event_pulse
);
    logic meta_q;
    logic sync_q;
    logic prev_q;
    logic pulse_q;
    logic hit;

    // only sync_q, prev_q and polarity_rise feed the edge decision
    assign hit = polarity_rise ? (sync_q && !prev_q) : (!sync_q && prev_q);
    assign event_pulse = pulse_q;

    always_ff @(posedge ref_clk)
    begin
        if (!rstn)
        begin
            meta_q <= 1'b0;
            sync_q <= 1'b0;
            prev_q <= 1'b0;
            pulse_q <= 1'b0;
        end
        else
        begin
            meta_q <= pin_in;
            sync_q <= meta_q;
            prev_q <= sync_q;
            pulse_q <= enable && hit;
        end
    end
endmodule : capture_sync

// ===== rtl/prescaler.sv
`timescale 1ns/1ns
module prescaler
    import rtc_pkg::*;
(
    input wire logic ref_clk,
    input wire logic rstn,
    input wire logic run,
    input wire logic lf_edge,
    tick_if.src tk
);
    logic [FRAC_W-1:0] frac_q;
    logic [FRAC_W-1:0] frac_d;
    logic tick_q;
    logic [FRAC_W-1:0] mask;
    logic wrap;

    // basic variant fixed at full 15-bit divide, fine variant 2^exp
    assign mask = tk.fine ? FRAC_W'((17'h1 << tk.exp_sel) - 17'h1) : SEC_DIV_MAX;
    assign wrap = lf_edge && ((frac_q & mask) == mask);
    assign frac_d = (run && lf_edge) ? frac_q + FRAC_W'(1) : frac_q;
    assign tk.tick = tick_q;
    assign tk.frac = frac_q;

    always_ff @(posedge ref_clk)
    begin
        if (!rstn)
        begin
            frac_q <= FRAC_RST;
            tick_q <= 1'b0;
        end
        else
        begin
            frac_q <= frac_d;
            tick_q <= run && wrap;
        end
    end
endmodule : prescaler

// ===== rtl/real_time_counter.sv
`timescale 1ns/1ns
// Behaviour
// - alarm flag and irq when alarm value equals the count
// - trim adds or removes a programmed amount at a fixed interval
// - basic variant divides by 32768, counting whole seconds
// - fine variant divides by 2^exp, exp 0 to 15
// - fine variant clocked from crystal or internal osc per selector
// - fine alarm resolves one 32 kHz cycle
// - basic variant has one absolute alarm that fires once
// - fine variant adds a periodic alarm every 60 units
// - strobe pulses when scheduled target time is reached
// - strobe can run as a divided clock of the selected 32 kHz source
// - strobe keeps working in active, flexible and hibernate modes
// - capture edge latches the current count
// - capture can wake the chip and interrupt the processor
// - snapshot names the exact 32 kHz cycle and stays readable
// - both variants share one 32768 Hz crystal oscillator
module real_time_counter
    import rtc_pkg::*;
(
    // clock and reset
    input wire logic ref_clk,
    input wire logic rstn,
    // low-frequency sources, each a one-cycle pulse per 32 kHz period, and the source select
    input wire logic low_freq_crystal_osc,
    input wire logic low_freq_internal_osc,
    input wire logic low_freq_clock_select,
    // configuration
    input wire logic enable,
    input wire logic fine_resolution_counter,
    input wire logic [EXP_W-1:0] prescale_exp,
    input wire logic load_count,
    input wire logic [CNT_W-1:0] load_value,
    input wire logic alarm_enable,
    input wire logic [CNT_W-1:0] alarm_count,
    input wire logic [FRAC_W-1:0] alarm_frac,
    input wire logic periodic_enable,
    input wire logic trim_enable,
    input wire logic trim_add,
    input wire logic [3:0] trim_amount,
    input wire logic [15:0] trim_interval,
    // strobe
    input wire logic strobe_enable,
    input wire logic strobe_clock_mode,
    input wire logic [CNT_W-1:0] strobe_target,
    input wire logic [15:0] strobe_div,
    // capture
    input wire logic capture_enable,
    input wire logic capture_rise,
    input wire logic capture_pin,
    // flag clears, one-cycle pulses
    input wire logic alarm_clear,
    input wire logic periodic_clear,
    input wire logic capture_clear,
    // status
    output logic [CNT_W-1:0] count,
    output logic [FRAC_W-1:0] count_frac,
    output logic alarm_flag,
    output logic periodic_flag,
    output logic capture_flag,
    output logic [CNT_W-1:0] capture_count,
    output logic [FRAC_W-1:0] capture_frac,
    output logic irq,
    output logic wake,
    output logic sensor_trigger_output
);
    tick_if tk();

    logic [CNT_W-1:0] cnt_q;
    logic [CNT_W-1:0] cnt_d;
    logic alarm_q;
    logic alarm_armed_q;
    logic periodic_q;
    logic [7:0] period_q;
    logic capture_q;
    logic [CNT_W-1:0] cap_cnt_q;
    logic [FRAC_W-1:0] cap_frac_q;
    logic [15:0] trim_cnt_q;
    logic [15:0] sdiv_q;
    logic strobe_q;
    logic irq_q;
    logic wake_q;
    logic [FRAC_W-1:0] frac_out_q;
    logic lf_edge;
    logic run;
    logic fine;
    logic trim_due;
    logic alarm_hit;
    logic period_hit;
    logic cap_evt;
    logic strobe_hit;
    logic sdiv_wrap;
    logic [CNT_W-1:0] trimmed;

    function automatic logic [CNT_W-1:0] adjust(input logic [CNT_W-1:0] v,
                                               input logic add,
                                               input logic [3:0] amt);
        adjust = add ? v + CNT_W'(amt) : v - CNT_W'(amt);
    endfunction : adjust

    assign fine = fine_resolution_counter;
    // basic variant runs only from the crystal
    assign lf_edge = (fine && low_freq_clock_select) ? low_freq_internal_osc
                                                    : low_freq_crystal_osc;
    assign run = enable;
    assign tk.fine = fine;
    assign tk.exp_sel = prescale_exp;

    prescaler u_pre (
        .ref_clk(ref_clk),
        .rstn(rstn),
        .run(run),
        .lf_edge(lf_edge),
        .tk(tk)
    );

    capture_sync u_cap (
        .ref_clk(ref_clk),
        .rstn(rstn),
        .enable(capture_enable && fine && run),
        .polarity_rise(capture_rise),
        .pin_in(capture_pin),
        .event_pulse(cap_evt)
    );

    assign trim_due = trim_enable && tk.tick && (trim_cnt_q == trim_interval);
    assign trimmed = adjust(cnt_q, trim_add, trim_amount);
    assign cnt_d = load_count ? load_value
                 : tk.tick ? (trim_due ? trimmed + CNT_W'(1) : cnt_q + CNT_W'(1))
                 : cnt_q;
    // fine alarm also matches the 32 kHz position inside the unit
    assign alarm_hit = alarm_enable && alarm_armed_q && run && (cnt_q == alarm_count)
                     && (!fine || (tk.frac == alarm_frac));
    assign period_hit = fine && periodic_enable && tk.tick && (period_q == PERIOD_LAST);
    // pulse in the cycle the count becomes the target, not when it leaves it
    assign strobe_hit = fine && strobe_enable && !strobe_clock_mode && run
                      && tk.tick && !load_count && (cnt_d == strobe_target);
    assign sdiv_wrap = lf_edge && (sdiv_q == strobe_div);

    assign count = cnt_q;
    assign count_frac = frac_out_q;
    assign alarm_flag = alarm_q;
    assign periodic_flag = periodic_q;
    assign capture_flag = capture_q;
    assign capture_count = cap_cnt_q;
    assign capture_frac = cap_frac_q;
    assign irq = irq_q;
    assign wake = wake_q;
    assign sensor_trigger_output = strobe_q;

    always_ff @(posedge ref_clk)
    begin
        if (!rstn)
        begin
            cnt_q <= CNT_RST;
            trim_cnt_q <= TRIM_INTERVAL_RST;
            period_q <= 8'h00;
            frac_out_q <= FRAC_RST;
        end
        else
        begin
            cnt_q <= cnt_d;
            frac_out_q <= tk.frac;
            if (tk.tick)
            begin
                // interval restarts on every tick while trim is off, so the first trim is on time
                trim_cnt_q <= (trim_due || !trim_enable) ? TRIM_INTERVAL_RST
                            : trim_cnt_q + 16'h0001;
                period_q <= (period_q == PERIOD_LAST) ? 8'h00 : period_q + 8'h01;
            end
        end
    end

    // alarm fires once until software rearms by clearing
    always_ff @(posedge ref_clk)
    begin
        if (!rstn)
        begin
            alarm_q <= 1'b0;
            alarm_armed_q <= 1'b1;
        end
        else
        begin
            if (alarm_hit)
            begin
                alarm_q <= 1'b1;
                alarm_armed_q <= 1'b0;
            end
            else if (alarm_clear)
            begin
                alarm_q <= 1'b0;
                alarm_armed_q <= 1'b1;
            end
        end
    end

    always_ff @(posedge ref_clk)
    begin
        if (!rstn)
        begin
            periodic_q <= 1'b0;
            capture_q <= 1'b0;
            cap_cnt_q <= CNT_RST;
            cap_frac_q <= FRAC_RST;
        end
        else
        begin
            periodic_q <= period_hit || (periodic_q && !periodic_clear);
            capture_q <= cap_evt || (capture_q && !capture_clear);
            if (cap_evt)
            begin
                cap_cnt_q <= cnt_q;
                cap_frac_q <= tk.frac;
            end
        end
    end

    // strobe has no power-mode gating, so it runs in every mode
    always_ff @(posedge ref_clk)
    begin
        if (!rstn)
        begin
            sdiv_q <= STROBE_DIV_RST;
            strobe_q <= 1'b0;
            irq_q <= 1'b0;
            wake_q <= 1'b0;
        end
        else
        begin
            sdiv_q <= (sdiv_wrap || !strobe_clock_mode) ? STROBE_DIV_RST
                    : lf_edge ? sdiv_q + 16'h0001 : sdiv_q;
            if (!fine || !strobe_enable || !run)
                strobe_q <= 1'b0;
            else if (strobe_clock_mode)
                strobe_q <= sdiv_wrap ? !strobe_q : strobe_q;
            else
                strobe_q <= strobe_hit;
            irq_q <= alarm_hit || period_hit || cap_evt || alarm_q || periodic_q || capture_q;
            wake_q <= cap_evt || capture_q;
        end
    end
endmodule : real_time_counter

// ===== rtl/rtc_pkg.sv
package rtc_pkg;
    localparam int CNT_W = 32;
    localparam int FRAC_W = 15;
    localparam int EXP_W = 4;
    localparam logic [FRAC_W-1:0] SEC_DIV_MAX = 15'h7FFF;
    localparam logic [EXP_W-1:0] EXP_MAX = 4'hF;
    localparam logic [7:0] PERIOD_UNITS = 8'h3C;
    localparam logic [7:0] PERIOD_LAST = 8'h3B;
    localparam logic [15:0] TRIM_INTERVAL_RST = 16'h0000;
    localparam logic [CNT_W-1:0] CNT_RST = 32'h0000_0000;
    localparam logic [FRAC_W-1:0] FRAC_RST = 15'h0000;
    localparam logic [15:0] STROBE_DIV_RST = 16'h0000;
    localparam int XTAL_HZ = 32768;
    localparam int REF_CLK_NS = 100;

    typedef enum logic [1:0] {
        VAR_SECONDS = 2'b00,
        VAR_FINE = 2'b01
    } variant_t;
endpackage : rtc_pkg

// ===== rtl/tick_if.sv
`timescale 1ns/1ns
interface tick_if;
    logic tick;
    logic [rtc_pkg::FRAC_W-1:0] frac;
    logic fine;
    logic [rtc_pkg::EXP_W-1:0] exp_sel;
    modport src(output tick, output frac, input fine, input exp_sel);
    modport dst(input tick, input frac, output fine, output exp_sel);
endinterface : tick_if

// ===== test/real_time_counter_asserts.sv
`timescale 1ns/1ns
module real_time_counter_asserts
    import rtc_pkg::*;
(
    // clock and reset
    input wire logic ref_clk,
    input wire logic rstn,
    // controls
    input wire logic enable,
    input wire logic fine_resolution_counter,
    input wire logic load_count,
    input wire logic [CNT_W-1:0] load_value,
    input wire logic capture_enable,
    input wire logic capture_rise,
    input wire logic capture_pin,
    input wire logic alarm_clear,
    // status
    input wire logic [CNT_W-1:0] count,
    input wire logic alarm_flag,
    input wire logic capture_flag,
    input wire logic irq,
    input wire logic wake,
    input wire logic sensor_trigger_output
);
    default clocking @(posedge ref_clk);
    endclocking
    default disable iff (!rstn);

    chk_alarm_irq: assert property (alarm_flag && $past(alarm_flag) |-> irq)
        else $error("alarm flag without irq");
    chk_alarm_sticky: assert property (alarm_flag && !alarm_clear |=> alarm_flag)
        else $error("alarm flag dropped without clear");
    chk_capture_wake: assert property (capture_flag && $past(capture_flag) |-> wake)
        else $error("capture pending without wake");
    chk_load_value: assert property (load_count |=> count == $past(load_value))
        else $error("count did not take load value");
    chk_stop_hold: assert property ((!enable)[*3] ##0 !load_count |=> $stable(count))
        else $error("count moved while disabled");
    chk_capture_late: assert property ($rose(capture_pin) && capture_rise && capture_enable
        && enable && fine_resolution_counter |-> ##[1:5] capture_flag)
        else $error("capture flag missing after pin edge");
    chk_basic_strobe: assert property ((!fine_resolution_counter)[*3] |-> !sensor_trigger_output)
        else $error("strobe in basic variant");
    chk_basic_capture: assert property ((!fine_resolution_counter && !capture_flag)[*5]
        |=> !capture_flag)
        else $error("capture in basic variant");

    cover property ($rose(alarm_flag));
    cover property ($rose(capture_flag));
    cover property ($rose(sensor_trigger_output));
endmodule : real_time_counter_asserts

bind real_time_counter real_time_counter_asserts i_real_time_counter_asserts (.*);

// ===== test/real_time_counter_bench.sv
`timescale 1ns/1ns
module real_time_counter_bench import rtc_pkg::*;;
    logic ref_clk = '0, rstn = '0, low_freq_crystal_osc = '0, low_freq_internal_osc = '0;
    logic low_freq_clock_select = '0, enable = '0, fine_resolution_counter = '0;
    logic load_count = '0, alarm_enable = '0, periodic_enable = '0, trim_enable = '0;
    logic trim_add = '0, strobe_enable = '0, strobe_clock_mode = '0, capture_enable = '0;
    logic capture_rise = '1, alarm_clear = '0, periodic_clear = '0, capture_clear = '0;
    logic [EXP_W-1:0] prescale_exp = '0;
    logic [CNT_W-1:0] load_value = '0, alarm_count = '0, strobe_target = '0, v, count;
    logic [CNT_W-1:0] capture_count;
    logic [FRAC_W-1:0] alarm_frac = '0, count_frac, capture_frac;
    logic [3:0] trim_amount = '0, dly = '0;
    logic [15:0] trim_interval = '0, strobe_div = '0;
    logic capture_pin, alarm_flag, periodic_flag, capture_flag, irq, wake;
    logic sensor_trigger_output;
    int failures = 0, n_compared = 0, rises = 0, seed = 32'h4BF8, e, n, c, ph = 0;

    real_time_counter i_real_time_counter (.*);
    sensor_model i_sensor_model (.ref_clk, .strobe(sensor_trigger_output), .delay(dly),
        .pin(capture_pin));

    always #(REF_CLK_NS / 2) ref_clk = ~ref_clk;
    always @(posedge sensor_trigger_output) rises++;

    function automatic logic [CNT_W-1:0] expect_count(input logic [CNT_W-1:0] s, int t, int st);
        return s + CNT_W'(t * st);
    endfunction : expect_count

    // ticks from n pulses when the prescaler phase starts at ph
    function automatic int expect_ticks(input int ph, input int n, input int e);
        return ((ph % (1 << e)) + n) >> e;
    endfunction : expect_ticks

    task automatic chk(input logic [CNT_W-1:0] got, input logic [CNT_W-1:0] want);
        n_compared++;
        if (got !== want)
        begin
            failures++;
            $display("[ERR] %0t got %h want %h", $time, got, want);
        end
    endtask : chk

    // k one-cycle pulses on one source, then let the pipeline settle
    task automatic lf(input int k, input logic src);
        repeat (k)
        begin
            @(posedge ref_clk);
            low_freq_crystal_osc <= !src;
            low_freq_internal_osc <= src;
            @(posedge ref_clk);
            low_freq_crystal_osc <= '0;
            low_freq_internal_osc <= '0;
        end
        repeat (4) @(posedge ref_clk);
    endtask : lf

    task automatic ld(input logic [CNT_W-1:0] val);
        load_value <= val;
        load_count <= '1;
        @(posedge ref_clk);
        load_count <= '0;
    endtask : ld

    task automatic clr;
        {alarm_clear, periodic_clear, capture_clear} <= 3'h7;
        @(posedge ref_clk);
        {alarm_clear, periodic_clear, capture_clear} <= 3'h0;
        @(posedge ref_clk);
    endtask : clr

    task automatic end_of_test;
        $display("compared %0d failures %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : end_of_test

    initial
    begin
        repeat (90000) @(posedge ref_clk);
        failures++;
        end_of_test();
    end

    initial
    begin
        repeat (2) @(posedge ref_clk);
        rstn <= '1;
        repeat (4) @(posedge ref_clk);
        {enable, alarm_enable, strobe_enable, capture_enable} <= 4'hF;
        v = $random(seed);
        alarm_count <= v + 1;
        ld(v);
        low_freq_clock_select <= '1;
        lf(3, 1);
        low_freq_clock_select <= '0;
        chk(count, v);
        lf(SEC_DIV_MAX, 0);
        chk({alarm_flag, count}, {1'b0, v});
        lf(1, 0);
        chk({alarm_flag, count}, {1'b1, v + 1});
        chk({sensor_trigger_output, capture_flag, wake}, 0);
        $display("test basic done");
        {alarm_enable, strobe_enable} <= 2'h0;
        clr();
        fine_resolution_counter <= '1;
        repeat (6)
        begin
            e = $unsigned($random(seed)) % 4;
            n = (1 << e) * (1 + $unsigned($random(seed)) % 4);
            c = $random(seed);
            v = $random(seed);
            prescale_exp <= e;
            low_freq_clock_select <= c[0];
            ld(v);
            lf(n, c[0]);
            lf(2, !c[0]);
            chk(count, expect_count(v, expect_ticks(ph, n, e), 1));
            ph = (ph + n) % (1 << FRAC_W);
        end
        $display("test prescale done");
        {prescale_exp, low_freq_clock_select} <= 5'h4;
        n = (4 - ph % 4) % 4;
        lf(n, 0);
        ph = ph + n;
        v = $random(seed);
        {alarm_count, alarm_frac, alarm_enable} <= {v + 32'h1, FRAC_W'(ph + 5), 1'b1};
        ld(v);
        lf(4, 0);
        chk(alarm_flag, 0);
        lf(1, 0);
        chk({alarm_flag, irq}, 2'h3);
        chk(count_frac, FRAC_W'(ph + 5));
        alarm_enable <= '0;
        clr();
        chk(alarm_flag, 0);
        $display("test alarm done");
        {prescale_exp, trim_enable} <= 5'h1;
        for (c = 0; c < 2; c++)
        begin
            n = $unsigned($random(seed)) % 16;
            {trim_amount, trim_add} <= {n[3:0], c[0]};
            ld(v);
            lf(4, 0);
            chk(count, expect_count(v, 4, c ? 1 + n : 1 - n));
        end
        {trim_enable, periodic_enable} <= 2'h1;
        for (c = 0; c < 61 && periodic_flag !== 1'b1; c++) lf(1, 0);
        clr();
        for (c = 0; c < 70 && periodic_flag !== 1'b1; c++) lf(1, 0);
        chk(c, PERIOD_UNITS);
        $display("test trim and periodic done");
        {periodic_enable, strobe_enable, capture_enable} <= 3'h3;
        for (e = 0; e < 2; e++)
        begin
            clr();
            dly <= e ? 4'h8 : 4'h1;
            v = $random(seed);
            strobe_target <= v + 3;
            ld(v);
            lf(2, 0);
            chk(capture_flag, 0);
            lf(1, 0);
            for (n = 0; n < 20 && capture_flag !== 1'b1; n++) @(posedge ref_clk);
            chk({capture_flag, wake}, 2'h3);
            chk(capture_count, v + 3);
            chk(capture_frac, count_frac);
        end
        {capture_enable, strobe_clock_mode, strobe_div} <= {2'h1, 16'h0001};
        clr();
        rises = 0;
        lf(8, 0);
        chk(rises, 2);
        {strobe_enable, enable} <= 2'h0;
        v = count;
        lf(3, 0);
        chk(count, v);
        $display("test strobe and capture done");
        end_of_test();
    end
endmodule : real_time_counter_bench

// ===== test/sensor_model.sv
`timescale 1ns/1ns
module sensor_model
(
    // trigger in, event out
    input wire logic ref_clk,
    input wire logic strobe,
    input wire logic [3:0] delay,
    output logic pin
);
    int n = -2;
    initial pin = 1'b0;
    // each trigger is answered by a two-cycle event pulse after delay cycles
    always @(posedge ref_clk)
    begin
        pin <= n inside {0, -1};
        if (strobe)
            n = delay;
        else if (n > -2)
            n = n - 1;
    end
endmodule : sensor_model
